// ==== core/tie_top.sv ====
// Purpose: six-channel timer interrupt enable and status registers on Avalon-MM
// Assumes: datapath delivers overflow, underflow, match and direction signals
// Notes: one wait cycle per access, read data registered
`timescale 1ns/1ps
`default_nettype none
module tie_top (
    input wire logic clk, // 25 MHz system clock
    input wire logic rst_n, // sync reset, active low
    input wire logic hw_standby, // hardware standby, active high
    input wire logic [5:0] address, // byte address
    input wire logic read, // read request
    input wire logic write, // write request
    input wire logic [31:0] writedata, // write data
    input wire logic [3:0] byteenable, // byte lanes
    output logic [31:0] readdata, // read data
    output logic waitrequest, // wait, active high
    input wire logic [5:0] overflow_evt, // counter wrapped FFFF to 0000
    input wire logic [5:0] underflow_evt, // counter stepped 0000 to FFFF
    input wire logic [5:0] count_up, // counter counts up
    input wire logic [5:0] match_a_evt, // compare or capture on reg a
    input wire logic [5:0] match_b_evt, // compare or capture on reg b
    input wire logic [5:0] match_c_evt, // compare or capture on reg c
    input wire logic [5:0] match_d_evt, // compare or capture on reg d
    input wire logic [5:0] xfer_start_a, // transfer controller started by a
    input wire logic [5:0] xfer_start_b, // transfer controller started by b
    input wire logic [5:0] xfer_start_c, // transfer controller started by c
    input wire logic [5:0] xfer_start_d, // transfer controller started by d
    input wire logic [5:0] transfer_disable_select_a, // keep flag a
    input wire logic [5:0] transfer_disable_select_b, // keep flag b
    input wire logic [5:0] transfer_disable_select_c, // keep flag c
    input wire logic [5:0] transfer_disable_select_d, // keep flag d
    output logic [5:0] underflow_irq, // underflow requests
    output logic [5:0] overflow_irq, // overflow requests
    output logic [5:0] match_a_irq, // match a requests
    output logic [5:0] match_b_irq, // match b requests
    output logic [5:0] match_c_irq, // match c requests
    output logic [5:0] match_d_irq, // match d requests
    output logic [5:0] converter_trigger // converter start pulses
);
    logic wait_reg; // waitrequest flop
    logic [31:0] rdata_reg; // readdata flop
    logic acc_go; // access completes this edge
    logic wr_go; // write takes effect
    logic rd_go; // read sampled
    logic [7:0] rd_mux; // selected register
    logic [7:0] ier_w [tie_pkg::NCH]; // enable registers
    logic [7:0] sr_w [tie_pkg::NCH]; // status views
    logic [5:0] irq_w [tie_pkg::NCH]; // per channel requests
    logic [5:0] ier_hit; // enable register selected
    logic [5:0] sr_hit; // status register selected
    logic [5:0] trig_w; // trigger per channel

    // bus handshake: one wait cycle, then answer
    assign acc_go = (read || write) && !wait_reg;
    assign wr_go = acc_go && write && byteenable[0];
    assign rd_go = read && wait_reg;

    // waitrequest falls one cycle after a request, for one cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wait_reg <= 1'b1; // idle high
        end else if (!wait_reg) begin
            wait_reg <= 1'b1; // answered, wait again
        end else if (read || write) begin
            wait_reg <= 1'b0; // answer next cycle
        end
    end

    // read data mux over channel registers, unmapped reads zero
    always_comb begin
        rd_mux = 8'h00;
        for (int n = 0; n < tie_pkg::NCH; n++) begin
            if (ier_hit[n]) begin
                rd_mux = ier_w[n];
            end
            if (sr_hit[n]) begin
                rd_mux = sr_w[n];
            end
        end
    end

    // read data captured in the wait cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_reg <= 32'h0000_0000;
        end else if (rd_go) begin
            rdata_reg <= {24'h00_0000, rd_mux}; // upper bits zero
        end
    end

    assign readdata = rdata_reg;
    assign waitrequest = wait_reg;

    // per channel decode, registers and request wiring
    genvar g;
    generate
        for (g = 0; g < tie_pkg::NCH; g++) begin : gch
            localparam bit FOUR = tie_pkg::FOUR_CH[g]; // four-flag channel
            localparam logic [5:0] IER_A = 6'(tie_pkg::IER_BASE + 6'(g) * tie_pkg::STRIDE);
            localparam logic [5:0] SR_A = 6'(tie_pkg::SR_BASE + 6'(g) * tie_pkg::STRIDE);
            logic [5:0] set_v; // event vector
            logic [3:0] xs_v; // transfer start vector
            logic [3:0] xd_v; // disable-select vector

            assign ier_hit[g] = (address == IER_A);
            assign sr_hit[g] = (address == SR_A);
            assign set_v = {underflow_evt[g], overflow_evt[g], match_d_evt[g],
                            match_c_evt[g], match_b_evt[g], match_a_evt[g]};
            assign xs_v = {xfer_start_d[g], xfer_start_c[g], xfer_start_b[g],
                           xfer_start_a[g]};
            assign xd_v = {transfer_disable_select_d[g], transfer_disable_select_c[g],
                           transfer_disable_select_b[g], transfer_disable_select_a[g]};

            tie_channel #(.FOUR(FOUR)) u_ch (
                .clk(clk),
                .rst_n(rst_n),
                .standby(hw_standby),
                .ier_wr(wr_go && ier_hit[g]),
                .sr_wr(wr_go && sr_hit[g]),
                .sr_rd(rd_go && sr_hit[g]),
                .wdata(writedata[7:0]),
                .set_evt(set_v),
                .xfer_start(xs_v),
                .xfer_dis(xd_v),
                .cnt_up(count_up[g]),
                .ier_q(ier_w[g]),
                .sr_q(sr_w[g]),
                .irq_q(irq_w[g]),
                .trig_q(trig_w[g])
            );

            assign underflow_irq[g] = irq_w[g][tie_pkg::B_UNF];
            assign overflow_irq[g] = irq_w[g][tie_pkg::B_OVF];
            assign match_d_irq[g] = irq_w[g][tie_pkg::B_D];
            assign match_c_irq[g] = irq_w[g][tie_pkg::B_C];
            assign match_b_irq[g] = irq_w[g][tie_pkg::B_B];
            assign match_a_irq[g] = irq_w[g][tie_pkg::B_A];
            assign converter_trigger[g] = trig_w[g];

            // helper: flag read as one since last clear, as seen by software
            logic ovf_seen; // overflow read as one
            always_ff @(posedge clk) begin
                if (!rst_n || hw_standby) begin
                    ovf_seen <= 1'b0;
                end else if (!sr_w[g][tie_pkg::B_OVF]) begin
                    ovf_seen <= 1'b0;
                end else if (wr_go && sr_hit[g] && !writedata[tie_pkg::B_OVF]) begin
                    ovf_seen <= 1'b0; // a zero write uses up the read
                end else if (rd_go && sr_hit[g]) begin
                    ovf_seen <= 1'b1;
                end
            end

            // named steps: a zero or a one write to overflow accepted on this channel, no overflow event
            sequence ovf_zero_wr_s;
                wr_go && sr_hit[g] && !writedata[tie_pkg::B_OVF];
            endsequence
            sequence ovf_one_wr_s;
                wr_go && sr_hit[g] && writedata[tie_pkg::B_OVF];
            endsequence
            sequence ovf_quiet_s;
                !overflow_evt[g];
            endsequence

            // reset values after reset or standby
            ier_reset_a: assert property (@(posedge clk)
                $past(!rst_n || hw_standby) |-> ier_w[g] == tie_pkg::IER_RST)
                else $error("enable register not at reset value");
            sr_reset_a: assert property (@(posedge clk)
                $past(!rst_n || hw_standby) |-> sr_w[g] == tie_pkg::SR_RST)
                else $error("status register not at reset value");
            // reserved bits fixed
            resv_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
                ier_w[g][tie_pkg::B_RESV] && sr_w[g][tie_pkg::B_RESV])
                else $error("reserved bit 6 not one");
            if (FOUR) begin : gf
                absent_four_a: assert property (@(posedge clk) disable iff (!rst_n)
                    !ier_w[g][tie_pkg::B_UNF] && !sr_w[g][tie_pkg::B_UNF]
                    && sr_w[g][tie_pkg::B_DIR] && !underflow_irq[g])
                    else $error("underflow bits present on four-flag channel");
                d_xfer_clr_a: assert property (@(posedge clk)
                    disable iff (!rst_n || hw_standby)
                    xfer_start_d[g] && !transfer_disable_select_d[g] && !match_d_evt[g]
                    |=> !sr_w[g][tie_pkg::B_D] && !match_d_irq[g])
                    else $error("match d flag not cleared by transfer start");
                d_set_a: assert property (@(posedge clk)
                    disable iff (!rst_n || hw_standby)
                    match_d_evt[g] |=> sr_w[g][tie_pkg::B_D]
                    ##0 (match_d_irq[g] == ier_w[g][tie_pkg::B_D]))
                    else $error("match d event not flagged");
                c_keep_a: assert property (@(posedge clk)
                    disable iff (!rst_n || hw_standby)
                    sr_w[g][tie_pkg::B_C] && xfer_start_c[g] && transfer_disable_select_c[g]
                    |=> sr_w[g][tie_pkg::B_C])
                    else $error("match c flag cleared while disable-select set");
                c_set_a: assert property (@(posedge clk)
                    disable iff (!rst_n || hw_standby)
                    match_c_evt[g] |=> sr_w[g][tie_pkg::B_C])
                    else $error("match c event not flagged");
                cd_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
                    (match_c_irq[g] == (sr_w[g][tie_pkg::B_C] && ier_w[g][tie_pkg::B_C]))
                    && (match_d_irq[g] == (sr_w[g][tie_pkg::B_D] && ier_w[g][tie_pkg::B_D])))
                    else $error("match c or d request differs from flag and enable");
                d_keep_a: assert property (@(posedge clk)
                    disable iff (!rst_n || hw_standby)
                    sr_w[g][tie_pkg::B_D] && xfer_start_d[g] && transfer_disable_select_d[g]
                    |=> sr_w[g][tie_pkg::B_D])
                    else $error("match d flag cleared while disable-select set");
            end else begin : gt
                absent_two_a: assert property (@(posedge clk) disable iff (!rst_n)
                    ier_w[g][tie_pkg::B_D:tie_pkg::B_C] == 2'b00
                    && sr_w[g][tie_pkg::B_D:tie_pkg::B_C] == 2'b00
                    && !match_c_irq[g] && !match_d_irq[g])
                    else $error("match c/d bits present on two-flag channel");
                dir_flag_a: assert property (@(posedge clk)
                    disable iff (!rst_n || hw_standby)
                    1'b1 |=> sr_w[g][tie_pkg::B_DIR] == $past(count_up[g]))
                    else $error("direction flag does not follow counter");
                unf_set_a: assert property (@(posedge clk)
                    disable iff (!rst_n || hw_standby)
                    underflow_evt[g] |=> sr_w[g][tie_pkg::B_UNF])
                    else $error("underflow event not flagged");
                unf_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
                    underflow_irq[g] == (sr_w[g][tie_pkg::B_UNF] && ier_w[g][tie_pkg::B_UNF]))
                    else $error("underflow request differs from flag and enable");
            end
            // overflow set and request follow
            ovf_set_a: assert property (@(posedge clk)
                disable iff (!rst_n || hw_standby)
                overflow_evt[g] |=> sr_w[g][tie_pkg::B_OVF])
                else $error("overflow event not flagged");
            irq_match_a: assert property (@(posedge clk) disable iff (!rst_n)
                (overflow_irq[g] == (sr_w[g][tie_pkg::B_OVF] && ier_w[g][tie_pkg::B_OVF]))
                && (match_a_irq[g] == (sr_w[g][tie_pkg::B_A] && ier_w[g][tie_pkg::B_A]))
                && (match_b_irq[g] == (sr_w[g][tie_pkg::B_B] && ier_w[g][tie_pkg::B_B])))
                else $error("request differs from flag and enable");
            // clearing needs a prior read as one
            ovf_noread_a: assert property (@(posedge clk)
                disable iff (!rst_n || hw_standby)
                sr_w[g][tie_pkg::B_OVF] && !ovf_seen ##0 ovf_zero_wr_s
                |=> sr_w[g][tie_pkg::B_OVF])
                else $error("overflow cleared without prior read");
            ovf_clear_a: assert property (@(posedge clk)
                disable iff (!rst_n || hw_standby)
                ovf_seen ##0 ovf_zero_wr_s ##0 ovf_quiet_s |=> !sr_w[g][tie_pkg::B_OVF])
                else $error("overflow not cleared after read and zero write");
            ovf_one_a: assert property (@(posedge clk)
                disable iff (!rst_n || hw_standby)
                sr_w[g][tie_pkg::B_OVF] ##0 ovf_one_wr_s |=> sr_w[g][tie_pkg::B_OVF])
                else $error("writing one changed the overflow flag");
            // converter start gated by bit 7
            trig_gate_a: assert property (@(posedge clk)
                disable iff (!rst_n || hw_standby)
                1'b1 |=> converter_trigger[g] ==
                    ($past(match_a_evt[g]) && ier_w[g][tie_pkg::B_TRIG]))
                else $error("converter start not gated by enable");
            // enable write reaches the register
            ier_write_a: assert property (@(posedge clk)
                disable iff (!rst_n || hw_standby)
                wr_go && ier_hit[g] |=> ier_w[g][tie_pkg::B_OVF] == $past(writedata[4])
                && ier_w[g][1:0] == $past(writedata[1:0]))
                else $error("enable write not stored");
            // match a sets and auto-clears like match d
            a_set_a: assert property (@(posedge clk)
                disable iff (!rst_n || hw_standby)
                match_a_evt[g] |=> sr_w[g][tie_pkg::B_A])
                else $error("match a event not flagged");
            a_xfer_clr_a: assert property (@(posedge clk)
                disable iff (!rst_n || hw_standby)
                xfer_start_a[g] && !transfer_disable_select_a[g] && !match_a_evt[g]
                |=> !sr_w[g][tie_pkg::B_A] && !match_a_irq[g])
                else $error("match a flag not cleared by transfer start");
            // a flag only falls through one of its clearing paths
            ovf_fall_a: assert property (@(posedge clk)
                disable iff (!rst_n || hw_standby)
                $fell(sr_w[g][tie_pkg::B_OVF])
                |-> $past(ovf_seen && wr_go && sr_hit[g] && !writedata[tie_pkg::B_OVF]))
                else $error("overflow flag fell without a clear");
            a_fall_a: assert property (@(posedge clk)
                disable iff (!rst_n || hw_standby)
                $fell(sr_w[g][tie_pkg::B_A])
                |-> $past((wr_go && sr_hit[g]) || xfer_start_a[g]))
                else $error("match a flag fell without a clear");
        end
    endgenerate

    // bus answer one cycle after the request
    bus_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("waitrequest answer timing wrong");
    unmapped_rd_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_go && !(|ier_hit) && !(|sr_hit) |=> readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    // bus outputs idle right after reset
    bus_reset_a: assert property (@(posedge clk)
        $past(!rst_n) |-> waitrequest && readdata == 32'h0000_0000)
        else $error("bus outputs not idle after reset");
endmodule
`default_nettype wire

// ==== core/tie_pkg.sv ====
// Purpose: constants of the six-channel timer interrupt enable and status block
// Assumes: Avalon-MM word per register, data in bits 7:0
// Notes: channels 0 and 3 carry four match flags, the others two
package tie_pkg;
    localparam int NCH = 6; // channel count
    localparam int ADDR_W = 6; // byte address width
    // byte addresses: enable register of channel n at IER_BASE + n*STRIDE
    localparam logic [5:0] IER_BASE = 6'h00; // first enable register
    localparam logic [5:0] SR_BASE = 6'h20; // first status register
    localparam logic [5:0] STRIDE = 6'h04; // one aligned word each
    // channels with four match flags
    localparam logic [5:0] FOUR_CH = 6'h09; // channels 0 and 3
    // reset values
    localparam logic [7:0] IER_RST = 8'h40; // bit 6 reads one
    localparam logic [7:0] SR_RST = 8'hC0; // bits 7 and 6 read one
    // writable enable bits per channel kind
    localparam logic [7:0] IER_WM_FOUR = 8'h9F; // trigger, ovf, d, c, b, a
    localparam logic [7:0] IER_WM_TWO = 8'hB3; // trigger, unf, ovf, b, a
    // implemented status flags, bits 5:0
    localparam logic [5:0] FLAG_M_FOUR = 6'h1F; // ovf, d, c, b, a
    localparam logic [5:0] FLAG_M_TWO = 6'h33; // unf, ovf, b, a
    // bit positions
    localparam int B_TRIG = 7; // converter_trigger_enable
    localparam int B_DIR = 7; // count_direction_flag
    localparam int B_RESV = 6; // reserved, reads one
    localparam int B_UNF = 5; // underflow
    localparam int B_OVF = 4; // overflow
    localparam int B_D = 3; // match d
    localparam int B_C = 2; // match c
    localparam int B_B = 1; // match b
    localparam int B_A = 0; // match a
endpackage

// ==== core/tie_channel.sv ====
// Purpose: enable register, status flags and requests of one timer channel
// Assumes: events are one-cycle pulses from the counter datapath
// Notes: FOUR selects the four-flag channel layout
`timescale 1ns/1ps
`default_nettype none
module tie_channel #(
    parameter bit FOUR = 1'b0 // four-flag channel
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // sync reset, active low
    input wire logic standby, // hardware standby, acts as reset
    input wire logic ier_wr, // write enable register
    input wire logic sr_wr, // write status register
    input wire logic sr_rd, // status register read
    input wire logic [7:0] wdata, // write data
    input wire logic [5:0] set_evt, // unf, ovf, d, c, b, a events
    input wire logic [3:0] xfer_start, // transfer controller started by d..a
    input wire logic [3:0] xfer_dis, // disable-select per d..a
    input wire logic cnt_up, // counter direction, 1 up
    output logic [7:0] ier_q, // enable register
    output logic [7:0] sr_q, // status register view
    output logic [5:0] irq_q, // requests unf, ovf, d, c, b, a
    output logic trig_q // converter start request pulse
);
    localparam logic [7:0] IER_WM = FOUR ? tie_pkg::IER_WM_FOUR : tie_pkg::IER_WM_TWO;
    localparam logic [5:0] FLAG_M = FOUR ? tie_pkg::FLAG_M_FOUR : tie_pkg::FLAG_M_TWO;

    logic [7:0] ier_reg, ier_next; // enable bits
    logic [5:0] flag_reg, flag_next; // status flags
    logic [5:0] seen_reg, seen_next; // flag read as one
    logic [5:0] clr_v; // clear requests
    logic dir_reg; // direction flag
    logic [5:0] irq_reg; // request outputs
    logic trig_reg; // trigger output

    // next-state of flags and enables
    always_comb begin
        clr_v = 6'h00;
        if (sr_wr) begin
            clr_v = ~wdata[5:0] & seen_reg;
        end
        clr_v[3:0] = clr_v[3:0] | (xfer_start & ~xfer_dis);
        // set wins over clear
        flag_next = ((flag_reg & ~clr_v) | set_evt) & FLAG_M;
        seen_next = flag_next & ~clr_v & (seen_reg | ({6{sr_rd}} & flag_reg));
        ier_next = ier_wr ? ((wdata & IER_WM) | tie_pkg::IER_RST) : ier_reg;
    end

    // enable register
    always_ff @(posedge clk) begin
        if (!rst_n || standby) begin
            ier_reg <= tie_pkg::IER_RST;
        end else begin
            ier_reg <= ier_next;
        end
    end

    // status flags and read tracking
    always_ff @(posedge clk) begin
        if (!rst_n || standby) begin
            flag_reg <= tie_pkg::SR_RST[5:0];
            seen_reg <= 6'h00;
        end else begin
            flag_reg <= flag_next;
            seen_reg <= seen_next;
        end
    end

    // count direction, reads one on four-flag channels
    always_ff @(posedge clk) begin
        if (!rst_n || standby) begin
            dir_reg <= 1'b1;
        end else begin
            dir_reg <= FOUR ? 1'b1 : cnt_up;
        end
    end

    // requests follow flag and enable together
    always_ff @(posedge clk) begin
        if (!rst_n || standby) begin
            irq_reg <= 6'h00;
            trig_reg <= 1'b0;
        end else begin
            irq_reg <= flag_next & ier_next[5:0];
            trig_reg <= set_evt[tie_pkg::B_A] & ier_next[tie_pkg::B_TRIG];
        end
    end

    assign ier_q = ier_reg;
    assign sr_q = {dir_reg, 1'b1, flag_reg};
    assign irq_q = irq_reg;
    assign trig_q = trig_reg;
endmodule
`default_nettype wire

// ==== sim/tie_far_model.sv ====
// Purpose: stands for the counter datapath and the transfer controller
// Assumes: event pulses last one clock, levels change only between tests
// Notes: the testbench drives it through its two tasks
`timescale 1ns/1ps
`default_nettype none
module tie_far_model (
    input wire logic clk, // system clock
    output logic [35:0] ev, // unf, ovf, d, c, b, a pulses, six each
    output logic [23:0] xs, // transfer starts d..a
    output logic [23:0] ds, // disable select d..a
    output logic [5:0] up // count direction, 1 up
);
    // quiet lines at time zero
    initial begin
        ev = '0;
        xs = '0;
        ds = '0;
        up = '1;
    end
    // one-cycle pulse, launched just after an edge
    task pulse(input logic [35:0] e, input logic [23:0] x);
        ev <= e;
        xs <= x;
        @(posedge clk);
        ev <= '0;
        xs <= '0;
    endtask
    // level inputs
    task lv(input logic [23:0] d, input logic [5:0] u);
        ds <= d;
        up <= u;
    endtask
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Purpose: self-checking bench for the timer enable and status block
// Assumes: one wait cycle per bus access, events taken at the pulse edge
// Notes: model flags kept per channel, compared at every status register read
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, rst_n, stby, read, write; // control
    logic [5:0] address; // bus address
    logic [31:0] wdata; // write data
    wire [31:0] rdata; // read data
    wire wr; // waitrequest
    wire [35:0] ev, irq; // events, requests
    wire [23:0] xs, ds; // transfer starts, disables
    wire [5:0] up, trg; // direction, triggers
    int err_count, n_tests, seed; // counters, seed
    logic [7:0] ier[6]; // model enables
    logic [5:0] flg[6], seen[6]; // model flags, read-as-one marks
    always #20 clk = ~clk;
    tie_far_model i_far (.clk(clk), .ev(ev), .xs(xs), .ds(ds), .up(up));
    tie_top i_dut (.clk(clk), .rst_n(rst_n), .hw_standby(stby), .address(address),
        .read(read), .write(write), .writedata(wdata), .byteenable(4'hF),
        .readdata(rdata), .waitrequest(wr), .overflow_evt(ev[29:24]),
        .underflow_evt(ev[35:30]), .count_up(up), .match_a_evt(ev[5:0]),
        .match_b_evt(ev[11:6]), .match_c_evt(ev[17:12]), .match_d_evt(ev[23:18]),
        .xfer_start_a(xs[5:0]), .xfer_start_b(xs[11:6]), .xfer_start_c(xs[17:12]),
        .xfer_start_d(xs[23:18]), .transfer_disable_select_a(ds[5:0]),
        .transfer_disable_select_b(ds[11:6]), .transfer_disable_select_c(ds[17:12]),
        .transfer_disable_select_d(ds[23:18]), .underflow_irq(irq[35:30]),
        .overflow_irq(irq[29:24]), .match_d_irq(irq[23:18]), .match_c_irq(irq[17:12]),
        .match_b_irq(irq[11:6]), .match_a_irq(irq[5:0]), .converter_trigger(trg));
    function automatic logic four(int c);
        return c == 0 || c == 3;
    endfunction
    // expected status view
    function automatic logic [7:0] sre(int c);
        return {four(c) ? 1'b1 : up[c], 1'b1, flg[c]};
    endfunction
    // expected requests, flag and enable
    function automatic logic [35:0] irqe();
        logic [35:0] v;
        for (int c = 0; c < 6; c++) for (int k = 0; k < 6; k++) v[k*6+c] = flg[c][k] & ier[c][k];
        return v;
    endfunction
    task chk(input logic [35:0] got, input logic [35:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask
    task finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // bus access, held until waitrequest is seen low
    task acc(input logic [5:0] a, input logic w, input logic [7:0] d, input logic [7:0] e);
        int i;
        address <= a;
        wdata <= {24'h0, d};
        if (w) write <= 1'b1;
        else read <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (wr !== 1'b0 && i < 20);
        if (wr !== 1'b0) begin
            err_count++;
            finish_test();
        end
        if (!w) chk({4'h0, rdata}, {28'h0, e});
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    // read every status register, noting flags seen as one
    task rds();
        for (int c = 0; c < 6; c++) begin
            acc(tie_pkg::SR_BASE + 6'(c) * tie_pkg::STRIDE, 1'b0, 8'h00, sre(c));
            seen[c] = flg[c];
        end
    endtask
    // write every status register; only seen flags written zero clear
    task wrs(input logic [7:0] d);
        for (int c = 0; c < 6; c++) begin
            acc(tie_pkg::SR_BASE + 6'(c) * tie_pkg::STRIDE, 1'b1, d, 8'h00);
            flg[c] &= ~(seen[c] & ~d[5:0]);
            seen[c] &= d[5:0];
        end
    endtask
    // events and transfer starts; set wins over an automatic clear
    task evt(input logic [35:0] e, input logic [23:0] x);
        logic [5:0] t;
        i_far.pulse(e, x);
        for (int c = 0; c < 6; c++) begin
            for (int k = 0; k < 4; k++) begin
                if (x[k*6+c] && !ds[k*6+c]) begin
                    flg[c][k] = 1'b0;
                    seen[c][k] = 1'b0; // cleared flag needs a fresh read
                end
            end
            flg[c] |= {e[30+c], e[24+c], e[18+c], e[12+c], e[6+c], e[c]} &
                (four(c) ? tie_pkg::FLAG_M_FOUR : tie_pkg::FLAG_M_TWO);
            t[c] = e[c] & ier[c][7];
        end
        #1;
        chk({30'h0, trg}, {30'h0, t});
        chk(irq, irqe());
        @(posedge clk);
    endtask
    task model_rst();
        for (int c = 0; c < 6; c++) begin
            ier[c] = 8'h40;
            flg[c] = '0;
            seen[c] = '0;
        end
    endtask
    initial begin
        seed = 32'h8549;
        err_count = 0;
        n_tests = 0;
        clk = 0;
        rst_n = 0;
        stby = 0;
        read = 0;
        write = 0;
        address = '0;
        wdata = '0;
        model_rst();
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int c = 0; c < 6; c++) acc(6'(c) * tie_pkg::STRIDE, 1'b0, 8'h00, 8'h40);
        rds();
        acc(6'h18, 1'b1, 8'hFF, 8'h00);
        acc(6'h18, 1'b0, 8'h00, 8'h00);
        $display("reset test done");
        for (int c = 0; c < 6; c++) begin
            ier[c] = 8'($random(seed));
            acc(6'(c) * tie_pkg::STRIDE, 1'b1, ier[c], 8'h00);
            ier[c] = (ier[c] & (four(c) ? tie_pkg::IER_WM_FOUR : tie_pkg::IER_WM_TWO)) | 8'h40;
            acc(6'(c) * tie_pkg::STRIDE, 1'b0, 8'h00, ier[c]);
        end
        $display("enable test done");
        i_far.lv(24'($random(seed)), 6'($random(seed)));
        repeat (3) begin
            evt(36'($random(seed)), 24'h0);
            rds();
        end
        wrs(8'h00);
        evt('1, 24'h0);
        wrs(8'h00);
        rds();
        wrs(8'hFF);
        rds();
        wrs(8'h00);
        rds();
        $display("flag test done");
        evt('1, 24'h0);
        evt(36'h0, '1);
        evt(36'($random(seed)), '1);
        rds();
        stby <= 1'b1;
        repeat (2) @(posedge clk);
        stby <= 1'b0;
        @(posedge clk);
        model_rst();
        chk(irq, 36'h0);
        for (int c = 0; c < 6; c++) acc(6'(c) * tie_pkg::STRIDE, 1'b0, 8'h00, 8'h40);
        rds();
        $display("standby test done");
        finish_test();
    end
endmodule
`default_nettype wire
